// ---- hw/iolcr_bank.sv ----
// input voltage floor, input current ceiling and precharge registers
`timescale 1ns/1ps

module iolcr_bank
    import iolcr_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic        i_reg_wr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_rd,
    output logic [7:0]       o_reg_rdata,
    input  wire logic        i_reg_reset,
    input  wire logic        i_wdog_expire,
    input  wire logic        i_plugin_detect_done,
    input  wire logic        i_optimizer_started,
    input  wire logic        i_source_detect_done,
    input  wire logic [11:0] i_pin_limit_ma,
    input  wire logic        i_pin_function_en,
    output logic             o_battery_pin_drain_load_en,
    output logic             o_audible_band_avoid_active,
    output logic             o_adapter_auto_restore_en,
    output logic [12:0]      o_input_voltage_floor_mv,
    output logic [11:0]      o_input_current_ceiling_ma,
    output logic             o_optimizer_enable,
    output logic             o_optimizer_force_pending,
    output logic             o_source_detect_active,
    output logic [7:0]       o_precharge_termination
);
    import iolcr_pkg::*;

    // ****************************************************************
    // decode
    // ****************************************************************
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction

    logic wr_vfloor;
    logic wr_iceil;
    logic wr_preterm;
    logic full_restore;

    always_comb begin
        wr_vfloor    = i_reg_wr && hit(i_reg_addr, ADDR_VFLOOR);
        wr_iceil     = i_reg_wr && hit(i_reg_addr, ADDR_ICEIL);
        wr_preterm   = i_reg_wr && hit(i_reg_addr, ADDR_PRETERM);
        full_restore = i_reg_reset;
    end

    // ****************************************************************
    // voltage floor register
    // ****************************************************************
    logic       auto_restore_q;
    logic       drain_load_q;
    logic       avoid_dis_q;
    logic [4:0] floor_code_q;

    // bits 7..6: register reset and watchdog
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || full_restore || i_wdog_expire) begin
            auto_restore_q <= RST_VFLOOR[BIT_AUTO_RESTORE];
            drain_load_q   <= RST_VFLOOR[BIT_DRAIN_LOAD];
        end else if (wr_vfloor) begin
            auto_restore_q <= i_reg_wdata[BIT_AUTO_RESTORE];
            drain_load_q   <= i_reg_wdata[BIT_DRAIN_LOAD];
        end
    end

    // bits 5..0: register reset, not watchdog; bits 4..0 also on plug-in detection with auto-restore
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || full_restore) begin
            avoid_dis_q <= RST_VFLOOR[BIT_AVOID_DIS];
        end else if (wr_vfloor) begin
            avoid_dis_q <= i_reg_wdata[BIT_AVOID_DIS];
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n || full_restore) begin
            floor_code_q <= RST_VFLOOR[CODE_MSB:0];
        end else if (i_plugin_detect_done && auto_restore_q) begin
            floor_code_q <= RST_VFLOOR[CODE_MSB:0];
        end else if (wr_vfloor) begin
            floor_code_q <= i_reg_wdata[CODE_MSB:0];
        end
    end

    // ****************************************************************
    // current ceiling register
    // ****************************************************************
    logic       opt_en_q;
    logic [4:0] ceil_code_q;

    always_ff @(posedge i_clock) begin
        if (!i_rst_n || full_restore) begin
            opt_en_q    <= RST_ICEIL[BIT_OPT_ENABLE];
            ceil_code_q <= RST_ICEIL[CODE_MSB:0];
        end else if (wr_iceil) begin
            opt_en_q    <= i_reg_wdata[BIT_OPT_ENABLE];
            ceil_code_q <= i_reg_wdata[CODE_MSB:0];
        end
    end

    iolcr_trig_if opt_trg ();
    iolcr_trig_if det_trg ();

    // write of 0 leaves the flags alone; watchdog restores both
    assign opt_trg.set     = wr_iceil && i_reg_wdata[BIT_OPT_TRIGGER] && opt_en_q;
    assign opt_trg.clear   = i_optimizer_started;
    assign opt_trg.restore = full_restore || i_wdog_expire;
    assign det_trg.set     = wr_iceil && i_reg_wdata[BIT_DETECT_FORCE];
    assign det_trg.clear   = i_source_detect_done;
    assign det_trg.restore = full_restore || i_wdog_expire;

    iolcr_trig u_opt_trig (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .trg     (opt_trg)
    );

    iolcr_trig u_det_trig (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .trg     (det_trg)
    );

    // ****************************************************************
    // precharge and termination register
    // ****************************************************************
    logic [7:0] preterm_q;

    always_ff @(posedge i_clock) begin
        if (!i_rst_n || full_restore || i_wdog_expire) begin
            preterm_q <= RST_PRETERM;
        end else if (wr_preterm) begin
            preterm_q <= i_reg_wdata;
        end
    end

    // ****************************************************************
    // limit decoding
    // ****************************************************************
    iolcr_limit_if lim ();

    assign lim.floor_code   = floor_code_q;
    assign lim.ceil_code    = ceil_code_q;
    assign lim.pin_limit_ma = i_pin_limit_ma;
    assign lim.pin_en       = i_pin_function_en;

    iolcr_decode u_decode (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .lim     (lim)
    );

    assign o_input_voltage_floor_mv   = lim.floor_mv;
    assign o_input_current_ceiling_ma = lim.ceil_ma;
    assign o_optimizer_force_pending  = opt_trg.flag;
    assign o_source_detect_active     = det_trg.flag;

    // ****************************************************************
    // control outputs
    // ****************************************************************
    assign o_battery_pin_drain_load_en = drain_load_q;
    assign o_adapter_auto_restore_en   = auto_restore_q;
    assign o_optimizer_enable          = opt_en_q;
    assign o_precharge_termination     = preterm_q;

    logic avoid_active_q;

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            avoid_active_q <= ~RST_VFLOOR[BIT_AVOID_DIS];
        end else begin
            avoid_active_q <= ~avoid_dis_q;
        end
    end

    assign o_audible_band_avoid_active = avoid_active_q;

    // ****************************************************************
    // read path
    // ****************************************************************
    logic [7:0] rdata_q;

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            rdata_q <= 8'h00;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                ADDR_VFLOOR:  rdata_q <= {auto_restore_q, drain_load_q, avoid_dis_q,
                                          floor_code_q};
                ADDR_ICEIL:   rdata_q <= {opt_trg.flag, det_trg.flag, opt_en_q,
                                          ceil_code_q};
                ADDR_PRETERM: rdata_q <= preterm_q;
                default:      rdata_q <= 8'h00;
            endcase
        end
    end

    assign o_reg_rdata = rdata_q;

endmodule // iolcr_bank

// ---- hw/iolcr_pkg.sv ----
// constants for the input limit configuration register bank
// Contract
// - auto-restore set: floor field returns to default after plug-in source detection
// - drain load bit drives battery pin discharge load, default off
// - audible-band avoid disable: 0 keeps feature active, 1 suppresses it
// - floor code decodes to 3.9 V plus 100 mV per step, default 4.4 V
// - floor codes above 10h act as 5.5 V
// - voltage register: watchdog restores bits 7..6 only, register reset all bits
// - voltage register resets to 85h
// - current register at 03h resets to 39h with trigger, detect, enable, ceiling
// - writing 1 starts optimizer only when enabled; reads 0 after start
// - writing 1 to detect force begins source detection; 0 means idle
// - optimizer enable gates the optimizer, default enabled
// - ceiling code decodes to 500 mA plus 100 mA per step, default 3000 mA
// - ceiling codes above 1Ch act as 3300 mA
// - effective ceiling is the smaller of register and pin limit
// - current register: watchdog restores bits 7..6 only, register reset all bits
// - precharge/termination register at 04h resets to 22h
// - pin limit takes part only while its function enable is 1
package iolcr_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] ADDR_VFLOOR   = 8'h02;
    localparam logic [7:0] ADDR_ICEIL    = 8'h03;
    localparam logic [7:0] ADDR_PRETERM  = 8'h04;

    localparam logic [7:0] RST_VFLOOR    = 8'h85;
    localparam logic [7:0] RST_ICEIL     = 8'h39;
    localparam logic [7:0] RST_PRETERM   = 8'h22;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int BIT_AUTO_RESTORE = 7;
    localparam int BIT_DRAIN_LOAD   = 6;
    localparam int BIT_AVOID_DIS    = 5;
    localparam int BIT_OPT_TRIGGER  = 7;
    localparam int BIT_DETECT_FORCE = 6;
    localparam int BIT_OPT_ENABLE   = 5;
    localparam int CODE_MSB         = 4;

    // bits restored by watchdog expiry in both limit registers
    localparam logic [7:0] WDOG_MASK = 8'hc0;

    // ****************************************************************
    // encodings
    // ****************************************************************
    localparam logic [4:0]  FLOOR_CODE_MAX = 5'h10;
    localparam logic [12:0] FLOOR_BASE_MV  = 13'h0f3c;
    localparam logic [12:0] FLOOR_STEP_MV  = 13'h0064;
    localparam logic [4:0]  CEIL_CODE_MAX  = 5'h1c;
    localparam logic [11:0] CEIL_BASE_MA   = 12'h1f4;
    localparam logic [11:0] CEIL_STEP_MA   = 12'h064;

endpackage : iolcr_pkg

// ---- hw/iolcr_if.sv ----
// interfaces between the register bank and its helper modules
`timescale 1ns/1ps

interface iolcr_limit_if;
    logic [4:0]  floor_code;
    logic [4:0]  ceil_code;
    logic [11:0] pin_limit_ma;
    logic        pin_en;
    logic [12:0] floor_mv;
    logic [11:0] ceil_ma;

    modport bank    (output floor_code, ceil_code, pin_limit_ma, pin_en,
                     input  floor_mv, ceil_ma);
    modport decoder (input  floor_code, ceil_code, pin_limit_ma, pin_en,
                     output floor_mv, ceil_ma);
endinterface : iolcr_limit_if

interface iolcr_trig_if;
    logic set;
    logic clear;
    logic restore;
    logic flag;

    modport bank  (output set, clear, restore, input flag);
    modport owner (input  set, clear, restore, output flag);
endinterface : iolcr_trig_if

// ---- hw/iolcr_decode.sv ----
// decodes the limit codes into millivolts and milliamps
`timescale 1ns/1ps

module iolcr_decode
    import iolcr_pkg::*;
(
    input  wire logic    i_clock,
    input  wire logic    i_rst_n,
    iolcr_limit_if.decoder lim
);

    // ****************************************************************
    // arithmetic
    // ****************************************************************
    function automatic logic [4:0] clamp_code(input logic [4:0] code, input logic [4:0] top);
        clamp_code = (code > top) ? top : code;
    endfunction

    logic [4:0]  floor_c;
    logic [4:0]  ceil_c;
    logic [11:0] reg_ma;

    always_comb begin
        floor_c = clamp_code(lim.floor_code, FLOOR_CODE_MAX);
        ceil_c  = clamp_code(lim.ceil_code, CEIL_CODE_MAX);
        reg_ma  = CEIL_BASE_MA + 12'(ceil_c) * CEIL_STEP_MA;
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            lim.floor_mv <= FLOOR_BASE_MV + 13'(RST_VFLOOR[CODE_MSB:0]) * FLOOR_STEP_MV;
        end else begin
            lim.floor_mv <= FLOOR_BASE_MV + 13'(floor_c) * FLOOR_STEP_MV;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            lim.ceil_ma <= CEIL_BASE_MA + 12'(RST_ICEIL[CODE_MSB:0]) * CEIL_STEP_MA;
        end else if (lim.pin_en && (lim.pin_limit_ma < reg_ma)) begin
            lim.ceil_ma <= lim.pin_limit_ma;
        end else begin
            lim.ceil_ma <= reg_ma;
        end
    end

endmodule // iolcr_decode

// ---- hw/iolcr_trig.sv ----
// one self-clearing request flag: set by a write, cleared by its consumer
`timescale 1ns/1ps

module iolcr_trig (
    input  wire logic   i_clock,
    input  wire logic   i_rst_n,
    iolcr_trig_if.owner trg
);

    // restore beats everything; a set in the clearing cycle is kept
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            trg.flag <= 1'b0;
        end else if (trg.restore) begin
            trg.flag <= 1'b0;
        end else if (trg.set) begin
            trg.flag <= 1'b1;
        end else if (trg.clear) begin
            trg.flag <= 1'b0;
        end
    end

endmodule // iolcr_trig

// ---- test/iolcr_engine_model.sv ----
// behavioural optimizer and source-detection engines answering the triggers
`timescale 1ns/1ps
module iolcr_engine_model (
    input  wire logic       i_clock,
    input  wire logic       i_pending,
    input  wire logic       i_active,
    input  wire logic [3:0] i_lat,
    output logic            o_started,
    output logic            o_done
);
    logic [3:0] wait_q;
    // i_lat sets how slowly the engines take up a request
    always_ff @(posedge i_clock) begin
        wait_q <= (i_pending || i_active) ? wait_q + 4'h1 : 4'h0;
    end
    assign o_started = i_pending && (wait_q == i_lat);
    assign o_done    = i_active && (wait_q == i_lat);
endmodule // iolcr_engine_model

// ---- test/iolcr_bank_properties.sv ----
// concurrent checks on the register bank ports
`timescale 1ns/1ps
module iolcr_bank_properties
    import iolcr_pkg::*;
(
    input wire logic        i_clock,
    input wire logic        i_rst_n,
    input wire logic [7:0]  i_reg_addr,
    input wire logic        i_reg_wr,
    input wire logic [7:0]  i_reg_wdata,
    input wire logic        i_reg_rd,
    input wire logic [7:0]  o_reg_rdata,
    input wire logic        i_reg_reset,
    input wire logic        i_wdog_expire,
    input wire logic        i_plugin_detect_done,
    input wire logic        i_optimizer_started,
    input wire logic [11:0] i_pin_limit_ma,
    input wire logic        i_pin_function_en,
    input wire logic        o_battery_pin_drain_load_en,
    input wire logic        o_audible_band_avoid_active,
    input wire logic        o_adapter_auto_restore_en,
    input wire logic [12:0] o_input_voltage_floor_mv,
    input wire logic [11:0] o_input_current_ceiling_ma,
    input wire logic        o_optimizer_enable,
    input wire logic        o_optimizer_force_pending,
    input wire logic        o_source_detect_active
);
    // ********************
    // assertions
    // ********************
    wire logic wr2  = i_reg_wr && (i_reg_addr == ADDR_VFLOOR);
    wire logic wr3  = i_reg_wr && (i_reg_addr == ADDR_ICEIL);
    wire logic hold = i_reg_reset || i_wdog_expire;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    a_unmapped_read: assert property (
        i_reg_rd && (i_reg_addr < 8'h02 || i_reg_addr > 8'h04) |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_wdog_restore: assert property (
        i_wdog_expire && !i_reg_reset |=> o_adapter_auto_restore_en
        && !o_battery_pin_drain_load_en && !o_optimizer_force_pending && !o_source_detect_active)
        else $error("watchdog restore wrong");
    a_regrst_floor: assert property (
        i_reg_reset |=> ##1 o_input_voltage_floor_mv == 13'h1130 && o_audible_band_avoid_active)
        else $error("register reset defaults wrong");
    a_trig_gated: assert property (
        wr3 && i_reg_wdata[7] && !o_optimizer_enable && !o_optimizer_force_pending
        |=> !o_optimizer_force_pending) else $error("trigger not gated");
    a_trig_clear: assert property (
        o_optimizer_force_pending && i_optimizer_started && !(wr3 && i_reg_wdata[7])
        |=> !o_optimizer_force_pending) else $error("trigger stuck");
    a_detect_set: assert property (
        wr3 && i_reg_wdata[6] && !hold |=> o_source_detect_active)
        else $error("detection not started");
    a_plugin_floor: assert property (
        i_plugin_detect_done && o_adapter_auto_restore_en && !hold
        |=> ##1 o_input_voltage_floor_mv == 13'h1130) else $error("floor not restored");
    a_drain_follow: assert property (
        wr2 && !hold |=> o_battery_pin_drain_load_en == $past(i_reg_wdata[6]))
        else $error("drain load wrong");
    a_ceil_bound: assert property (
        $past(i_rst_n) |-> o_input_current_ceiling_ma <= 12'hce4
        && (!$past(i_pin_function_en) || o_input_current_ceiling_ma <= $past(i_pin_limit_ma)))
        else $error("ceiling above limit");
    a_floor_range: assert property (
        o_input_voltage_floor_mv <= 13'h157c && o_input_voltage_floor_mv >= 13'h0f3c)
        else $error("floor out of range");
endmodule // iolcr_bank_properties
bind iolcr_bank iolcr_bank_properties chk_u (
    .i_clock                     (i_clock),
    .i_rst_n                     (i_rst_n),
    .i_reg_addr                  (i_reg_addr),
    .i_reg_wr                    (i_reg_wr),
    .i_reg_wdata                 (i_reg_wdata),
    .i_reg_rd                    (i_reg_rd),
    .o_reg_rdata                 (o_reg_rdata),
    .i_reg_reset                 (i_reg_reset),
    .i_wdog_expire               (i_wdog_expire),
    .i_plugin_detect_done        (i_plugin_detect_done),
    .i_optimizer_started         (i_optimizer_started),
    .i_pin_limit_ma              (i_pin_limit_ma),
    .i_pin_function_en           (i_pin_function_en),
    .o_battery_pin_drain_load_en (o_battery_pin_drain_load_en),
    .o_audible_band_avoid_active (o_audible_band_avoid_active),
    .o_adapter_auto_restore_en   (o_adapter_auto_restore_en),
    .o_input_voltage_floor_mv    (o_input_voltage_floor_mv),
    .o_input_current_ceiling_ma  (o_input_current_ceiling_ma),
    .o_optimizer_enable          (o_optimizer_enable),
    .o_optimizer_force_pending   (o_optimizer_force_pending),
    .o_source_detect_active      (o_source_detect_active)
);

// ---- test/iolcr_bank_tb.sv ----
// self-checking bench for the input limit register bank
`timescale 1ns/1ps
module iolcr_bank_tb;
    import iolcr_pkg::*;
    logic        i_clock, i_rst_n, i_reg_wr, i_reg_rd, i_pin_function_en;
    logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata, o_precharge_termination;
    logic [11:0] i_pin_limit_ma, o_input_current_ceiling_ma;
    logic [12:0] o_input_voltage_floor_mv;
    logic        o_battery_pin_drain_load_en, o_audible_band_avoid_active;
    logic        o_adapter_auto_restore_en, o_optimizer_enable;
    logic        o_optimizer_force_pending, o_source_detect_active;
    logic        i_optimizer_started, i_source_detect_done;
    wire logic   i_reg_reset, i_wdog_expire, i_plugin_detect_done;
    logic [2:0]  pls;
    logic [3:0]  lat;
    int          mismatches, checked;
    logic [4:0]  fc[4]  = '{5'h00, 5'h10, 5'h11, 5'h1f};
    logic [12:0] fmv[4] = '{13'h0f3c, 13'h157c, 13'h157c, 13'h157c};
    logic [4:0]  cc[4]  = '{5'h00, 5'h1c, 5'h1d, 5'h1f};
    logic [12:0] cma[4] = '{13'h01f4, 13'h0ce4, 13'h0ce4, 13'h0ce4};
    assign {i_reg_reset, i_wdog_expire, i_plugin_detect_done} = pls;
    iolcr_bank dut_u (
        .i_clock                     (i_clock),
        .i_rst_n                     (i_rst_n),
        .i_reg_addr                  (i_reg_addr),
        .i_reg_wr                    (i_reg_wr),
        .i_reg_wdata                 (i_reg_wdata),
        .i_reg_rd                    (i_reg_rd),
        .o_reg_rdata                 (o_reg_rdata),
        .i_reg_reset                 (i_reg_reset),
        .i_wdog_expire               (i_wdog_expire),
        .i_plugin_detect_done        (i_plugin_detect_done),
        .i_optimizer_started         (i_optimizer_started),
        .i_source_detect_done        (i_source_detect_done),
        .i_pin_limit_ma              (i_pin_limit_ma),
        .i_pin_function_en           (i_pin_function_en),
        .o_battery_pin_drain_load_en (o_battery_pin_drain_load_en),
        .o_audible_band_avoid_active (o_audible_band_avoid_active),
        .o_adapter_auto_restore_en   (o_adapter_auto_restore_en),
        .o_input_voltage_floor_mv    (o_input_voltage_floor_mv),
        .o_input_current_ceiling_ma  (o_input_current_ceiling_ma),
        .o_optimizer_enable          (o_optimizer_enable),
        .o_optimizer_force_pending   (o_optimizer_force_pending),
        .o_source_detect_active      (o_source_detect_active),
        .o_precharge_termination     (o_precharge_termination)
    );
    iolcr_engine_model model_u (.i_clock, .i_pending(o_optimizer_force_pending),
        .i_active(o_source_detect_active), .i_lat(lat), .o_started(i_optimizer_started),
        .o_done(i_source_detect_done));
    // ********************
    // tasks
    // ********************
    task automatic cmp(input logic [12:0] act, input logic [12:0] exp);
        checked++;
        if (act !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, act, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clock);
        i_reg_wr = 1'h1;
        i_reg_addr = a;
        i_reg_wdata = d;
        @(negedge i_clock);
        i_reg_wr = 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge i_clock);
        i_reg_rd = 1'h1;
        i_reg_addr = a;
        @(negedge i_clock);
        i_reg_rd = 1'h0;
        cmp({5'h00, o_reg_rdata}, {5'h00, e});
    endtask
    task automatic pulse(input logic [2:0] p);
        @(negedge i_clock);
        pls = p;
        @(negedge i_clock);
        pls = 3'h0;
    endtask
    task automatic end_sim;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ********************
    // tests
    // ********************
    initial begin
        i_clock = 1'h0;
        forever #4 i_clock = ~i_clock;
    end
    initial begin
        #20000;
        mismatches++;
        end_sim();
    end
    initial begin
        {i_rst_n, i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata, pls} = '0;
        i_pin_function_en = 1'h1;
        i_pin_limit_ma = 12'hfff;
        lat = 4'hf;
        repeat (2) @(posedge i_clock);
        @(negedge i_clock);
        i_rst_n = 1'h1;
        rd(ADDR_VFLOOR, 8'h85);
        rd(ADDR_ICEIL, 8'h39);
        rd(ADDR_PRETERM, 8'h22);
        rd(8'h05, 8'h00);
        cmp(o_input_voltage_floor_mv, 13'h1130);
        cmp({1'h0, o_input_current_ceiling_ma}, 13'h0bb8);
        cmp({12'h000, o_audible_band_avoid_active}, 13'h0001);
        cmp({12'h000, o_optimizer_enable}, 13'h0001);
        cmp({12'h000, o_adapter_auto_restore_en}, 13'h0001);
        cmp({5'h00, o_precharge_termination}, 13'h0022);
        $display("defaults test done");
        i_pin_function_en = 1'h0;
        i_pin_limit_ma = 12'h000;
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_VFLOOR, {3'h7, fc[k]});
            wr(ADDR_ICEIL, {3'h1, cc[k]});
            @(negedge i_clock);
            cmp(o_input_voltage_floor_mv, fmv[k]);
            cmp({1'h0, o_input_current_ceiling_ma}, cma[k]);
        end
        cmp({12'h000, o_battery_pin_drain_load_en}, 13'h0001);
        cmp({12'h000, o_audible_band_avoid_active}, 13'h0000);
        i_pin_function_en = 1'h1;
        i_pin_limit_ma = 12'h3e8;
        @(negedge i_clock);
        cmp({1'h0, o_input_current_ceiling_ma}, 13'h03e8);
        i_pin_limit_ma = 12'hfff;
        $display("decode test done");
        wr(ADDR_VFLOOR, 8'h6f);
        wr(ADDR_ICEIL, 8'h6a);
        wr(ADDR_PRETERM, 8'h5a);
        rd(ADDR_PRETERM, 8'h5a);
        pulse(3'h2);
        rd(ADDR_VFLOOR, 8'haf);
        rd(ADDR_ICEIL, 8'h2a);
        rd(ADDR_PRETERM, 8'h22);
        pulse(3'h4);
        rd(ADDR_VFLOOR, 8'h85);
        rd(ADDR_ICEIL, 8'h39);
        $display("reset sources test done");
        lat = 4'h3;
        wr(ADDR_ICEIL, 8'hb9);
        rd(ADDR_ICEIL, 8'hb9);
        repeat (4) @(negedge i_clock);
        rd(ADDR_ICEIL, 8'h39);
        lat = 4'h0;
        wr(ADDR_ICEIL, 8'hb9);
        rd(ADDR_ICEIL, 8'h39);
        lat = 4'h3;
        wr(ADDR_ICEIL, 8'h79);
        @(negedge i_clock);
        cmp({12'h000, o_source_detect_active}, 13'h0001);
        repeat (4) @(negedge i_clock);
        rd(ADDR_ICEIL, 8'h39);
        wr(ADDR_ICEIL, 8'h19);
        wr(ADDR_ICEIL, 8'h99);
        rd(ADDR_ICEIL, 8'h19);
        cmp({12'h000, o_optimizer_enable}, 13'h0000);
        $display("trigger test done");
        wr(ADDR_VFLOOR, 8'h9f);
        pulse(3'h1);
        rd(ADDR_VFLOOR, 8'h85);
        wr(ADDR_VFLOOR, 8'h1f);
        pulse(3'h1);
        rd(ADDR_VFLOOR, 8'h1f);
        $display("plug-in test done");
        end_sim();
    end
endmodule // iolcr_bank_tb
